// ===== logic/nand_host_pkg.sv
// constants, register map and carrier types for the serial nand host
// assumes a 125 MHz system clock and a wishbone classic software port
package nand_host_pkg;

  // clock and link timing
  localparam int CLK_NS        = 8;
  localparam int SCK_HALF_NS   = 64;
  localparam int CS_HIGH_NS    = 100;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_HIGH_CYC   = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

  // device opcodes
  localparam logic [7:0] OPC_WREN   = 8'h06;
  localparam logic [7:0] OPC_LOAD   = 8'h02;
  localparam logic [7:0] OPC_RLOAD  = 8'h84;
  localparam logic [7:0] OPC_QLOAD  = 8'h32;
  localparam logic [7:0] OPC_QRLOAD = 8'h34;
  localparam logic [7:0] OPC_EXEC   = 8'h10;
  localparam logic [7:0] OPC_PREAD  = 8'h13;
  localparam logic [7:0] OPC_READ   = 8'h03;
  localparam logic [7:0] OPC_RDSR   = 8'h0f;
  localparam logic [7:0] SR3_ADDR   = 8'hc0;
  localparam int         SR3_BUSY   = 0;

  // geometry
  localparam logic [15:0] PAGE_BYTES  = 16'd2112;
  localparam int          BLK_SHIFT   = 6;
  localparam logic [2:0]  MAX_PARTIAL = 3'd4;

  // software command codes written to CMD
  localparam logic [3:0] CMD_WREN   = 4'h1;
  localparam logic [3:0] CMD_LOAD   = 4'h2;
  localparam logic [3:0] CMD_RLOAD  = 4'h3;
  localparam logic [3:0] CMD_QLOAD  = 4'h4;
  localparam logic [3:0] CMD_QRLOAD = 4'h5;
  localparam logic [3:0] CMD_EXEC   = 4'h6;
  localparam logic [3:0] CMD_PREAD  = 4'h7;
  localparam logic [3:0] CMD_READ   = 4'h8;
  localparam logic [3:0] CMD_RDSR   = 4'h9;

  // register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_LEN    = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0c;
  localparam logic [7:0] REG_TXDATA = 8'h10;
  localparam logic [7:0] REG_RXDATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // reset values
  localparam logic [2:0]  CFG_RESET  = 3'b001;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] LEN_RESET  = 16'h0001;

  // data phase kinds
  localparam logic [1:0] DM_NONE = 2'd0;
  localparam logic [1:0] DM_TX   = 2'd1;
  localparam logic [1:0] DM_RX   = 2'd2;

  typedef struct packed {
    logic       wp_quad_off;
    logic       long_dummy;
    logic       buf_mode;
  } cfg_t;

  typedef struct packed {
    logic [47:0] hdr;
    logic [5:0]  nbits;
    logic [1:0]  dmode;
    logic        quad;
  } frame_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } pins_t;

endpackage

// ===== logic/nand_host.sv
// host controller driving a serial nand through cs, sck and four io lines
// assumes software on wishbone classic; io pads resolved outside
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - load one to 2112 bytes, then execute
// - write enable issued before every load
// - load sends opcode, column, then data
// - chip select held low through load data
// - quad loads send data on four lines
// - execute sends 10h, dummy, page address
// - at most four partial programs per page (count restarts whenever an execute goes to another page)
// - pages in a block programmed ascending (checked only against the last executed page)
// - page read sends 13h, dummy, page
// - read sends 03h, column, 8/24 dummy
module nand_host
  import nand_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  io_i,
  output pins_t            pins_o
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_STALL = 4'b0100,
    ST_GAP   = 4'b1000
  } state_t;

  typedef enum logic [1:0] {
    U_HDR = 2'd0,
    U_TXD = 2'd1,
    U_RXD = 2'd2
  } unit_t;

  // software registers
  cfg_t        cfg_q;
  logic [31:0] addr_q;
  logic [15:0] len_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  // engine state
  state_t      state_q;
  unit_t       unit_q;
  logic [3:0]  job_q;
  logic        pre_q;
  logic        poll_q;
  logic        main_q;
  frame_t      frm_q;
  logic [47:0] sr_q;
  logic [5:0]  bits_q;
  logic [15:0] left_q;
  logic [7:0]  in_q;
  logic [7:0]  div_q;
  logic [7:0]  gap_q;
  logic        sck_q;
  logic        tx_full_q;
  logic [7:0]  tx_q;
  logic        rx_full_q;
  logic [7:0]  rx_q;
  logic [7:0]  stat_q;
  logic        err_q;
  logic        have_q;
  logic [15:0] last_pg_q;
  logic [2:0]  part_q;

  // input synchroniser
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic [3:0]  s3_q;
  logic [3:0]  din_q;

  logic        req;
  logic        wr_cmd;
  logic        wr_tx;
  logic        rd_rx;
  logic        tick;
  logic        start_ok;
  logic [15:0] page;
  logic [15:0] col;
  logic        dev_busy;

  assign req      = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_cmd   = req && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[0];
  assign wr_tx    = req && wb_we_i && wb_adr_i == REG_TXDATA && wb_sel_i[0];
  assign rd_rx    = req && !wb_we_i && wb_adr_i == REG_RXDATA;
  assign tick     = div_q == 8'h00;
  assign page     = addr_q[31:16];
  assign col      = {4'h0, addr_q[11:0]};
  assign dev_busy = stat_q[SR3_BUSY];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  function automatic logic is_quad(input logic [3:0] c);
    return c == CMD_QLOAD || c == CMD_QRLOAD;
  endfunction

  function automatic logic is_load(input logic [3:0] c);
    return c == CMD_LOAD || c == CMD_RLOAD || is_quad(c);
  endfunction

  // header and data phase for the next frame
  function automatic frame_t build(input logic wren, input logic poll,
                                   input logic [3:0] c);
    frame_t f;
    f = '0;
    if (wren) begin
      f.hdr   = {OPC_WREN, 40'h0};
      f.nbits = 6'd8;
    end else if (poll) begin
      f.hdr   = {OPC_RDSR, SR3_ADDR, 32'h0};
      f.nbits = 6'd16;
      f.dmode = DM_RX;
    end else begin
      case (c)
        CMD_WREN: begin
          f.hdr   = {OPC_WREN, 40'h0};
          f.nbits = 6'd8;
        end
        CMD_LOAD, CMD_RLOAD, CMD_QLOAD, CMD_QRLOAD: begin
          // normal loads pad the buffer with ffh, random ones keep it
          f.hdr   = {(c == CMD_LOAD)  ? OPC_LOAD :
                     (c == CMD_RLOAD) ? OPC_RLOAD :
                     (c == CMD_QLOAD) ? OPC_QLOAD : OPC_QRLOAD,
                     col, 24'h0};
          f.nbits = 6'd24;
          f.dmode = DM_TX;
          f.quad  = is_quad(c);
        end
        CMD_EXEC: begin
          f.hdr   = {OPC_EXEC, 8'h00, page, 16'h0};
          f.nbits = 6'd32;
        end
        CMD_PREAD: begin
          f.hdr   = {OPC_PREAD, 8'h00, page, 16'h0};
          f.nbits = 6'd32;
        end
        CMD_READ: begin
          f.hdr   = {OPC_READ, col, 24'h0};
          f.nbits = cfg_q.long_dummy ? 6'd48 : 6'd32;
          f.dmode = DM_RX;
        end
        CMD_RDSR: begin
          f.hdr   = {OPC_RDSR, SR3_ADDR, 32'h0};
          f.nbits = 6'd16;
          f.dmode = DM_RX;
        end
        default: f = '0;
      endcase
    end
    return f;
  endfunction

  // command legality, checked when software starts a command
  always_comb begin
    start_ok = 1'b1;
    if (job_valid(wb_dat_i[3:0]) == 1'b0) begin
      start_ok = 1'b0;
    end else if (is_quad(wb_dat_i[3:0]) && cfg_q.wp_quad_off) begin
      start_ok = 1'b0;
    end else if (is_load(wb_dat_i[3:0])) begin
      // length 1..2112 and within the buffer
      // one extra bit so a huge length cannot wrap past the check
      start_ok = len_q != 16'h0 &&
                 ({5'h00, addr_q[11:0]} + {1'b0, len_q}) <=
                 {1'b0, PAGE_BYTES};
    end else if (wb_dat_i[3:0] == CMD_READ) begin
      // buffer mode stops at the last byte, later clocks float
      start_ok = len_q != 16'h0 && (!cfg_q.buf_mode ||
                 ({5'h00, addr_q[11:0]} + {1'b0, len_q}) <=
                 {1'b0, PAGE_BYTES});
    end else if (wb_dat_i[3:0] == CMD_EXEC && have_q &&
                 page[15:BLK_SHIFT] == last_pg_q[15:BLK_SHIFT]) begin
      if (page < last_pg_q) begin
        start_ok = 1'b0;
      end else if (page == last_pg_q && part_q >= MAX_PARTIAL) begin
        start_ok = 1'b0;
      end
    end
  end

  function automatic logic job_valid(input logic [3:0] c);
    return c >= CMD_WREN && c <= CMD_RDSR;
  endfunction

  // bus registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
      cfg_q  <= CFG_RESET;
      addr_q <= ADDR_RESET;
      len_q  <= LEN_RESET;
    end else begin
      ack_q <= req;
      if (req && wb_we_i) begin
        case (wb_adr_i)
          REG_ADDR: begin
            if (wb_sel_i[0]) addr_q[7:0]   <= wb_dat_i[7:0];
            if (wb_sel_i[1]) addr_q[15:8]  <= wb_dat_i[15:8];
            if (wb_sel_i[2]) addr_q[23:16] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) addr_q[31:24] <= wb_dat_i[31:24];
          end
          REG_LEN: begin
            if (wb_sel_i[0]) len_q[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) len_q[15:8] <= wb_dat_i[15:8];
          end
          REG_CFG: begin
            if (wb_sel_i[0]) cfg_q <= wb_dat_i[2:0];
          end
          default: ;
        endcase
      end
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          REG_ADDR:   rdat_q <= addr_q;
          REG_LEN:    rdat_q <= {16'h0, len_q};
          REG_CFG:    rdat_q <= {29'h0, cfg_q};
          REG_RXDATA: rdat_q <= {24'h0, rx_q};
          REG_STATUS: rdat_q <= {16'h0, stat_q, 3'h0, dev_busy, err_q,
                                 rx_full_q, tx_full_q, state_q != ST_IDLE};
          default:    rdat_q <= 32'h0;
        endcase
      end
    end
  end

  // three-stage sampling of the io inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      din_q <= 4'h0;
    end else begin
      s1_q <= io_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 4; i++) begin
        if (s2_q[i] == s3_q[i]) din_q[i] <= s3_q[i];
      end
    end
  end

  // frame engine, mode 0: shift out on falling, sample on rising
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      unit_q    <= U_HDR;
      job_q     <= 4'h0;
      pre_q     <= 1'b0;
      poll_q    <= 1'b0;
      main_q    <= 1'b0;
      frm_q     <= '0;
      sr_q      <= 48'h0;
      bits_q    <= 6'h0;
      left_q    <= 16'h0;
      in_q      <= 8'h0;
      div_q     <= 8'h0;
      gap_q     <= 8'h0;
      sck_q     <= 1'b0;
      tx_full_q <= 1'b0;
      tx_q      <= 8'h0;
      rx_full_q <= 1'b0;
      rx_q      <= 8'h0;
      stat_q    <= 8'h0;
      err_q     <= 1'b0;
      have_q    <= 1'b0;
      last_pg_q <= 16'h0;
      part_q    <= 3'h0;
    end else begin
      if (rd_rx) rx_full_q <= 1'b0;
      if (wr_tx) begin
        tx_q      <= wb_dat_i[7:0];
        tx_full_q <= 1'b1;
      end
      div_q <= tick ? 8'(SCK_HALF_CYC - 1) : div_q - 8'h01;
      case (state_q)
        ST_IDLE: begin
          sck_q <= 1'b0;
          // busy is only cleared by polling, so a new job waits for it
          if (wr_cmd) begin
            if (start_ok) begin
              err_q  <= 1'b0;
              job_q  <= wb_dat_i[3:0];
              pre_q  <= is_load(wb_dat_i[3:0]) ||
                        wb_dat_i[3:0] == CMD_EXEC;
              poll_q <= 1'b0;
              main_q <= 1'b0;
              gap_q  <= 8'h00;
              state_q <= ST_GAP;
              if (wb_dat_i[3:0] == CMD_EXEC) begin
                have_q    <= 1'b1;
                last_pg_q <= page;
                part_q    <= (have_q && page == last_pg_q) ?
                             part_q + 3'h1 : 3'h1;
              end
            end else begin
              err_q <= 1'b1;
            end
          end
        end
        ST_GAP: begin
          sck_q <= 1'b0;
          if (gap_q < 8'(CS_HIGH_CYC)) begin
            gap_q <= gap_q + 8'h01;
          end else if (main_q && !poll_q && !pre_q &&
                       job_q != CMD_EXEC && job_q != CMD_PREAD) begin
            state_q <= ST_IDLE;
          end else if (poll_q && !dev_busy) begin
            state_q <= ST_IDLE;
          end else begin
            // next frame: wren, main, or another busy poll
            frm_q  <= build(pre_q, main_q, job_q);
            sr_q   <= build(pre_q, main_q, job_q).hdr;
            bits_q <= build(pre_q, main_q, job_q).nbits;
            poll_q <= main_q;
            main_q <= main_q | !pre_q;
            pre_q  <= 1'b0;
            left_q <= main_q ? 16'h1 : len_q;
            unit_q <= U_HDR;
            div_q  <= 8'(SCK_HALF_CYC - 1);
            state_q <= ST_SHIFT;
          end
        end
        ST_STALL: begin
          sck_q <= 1'b0;
          div_q <= 8'(SCK_HALF_CYC - 1);
          if (frm_q.dmode == DM_TX && tx_full_q && !wr_tx) begin
            sr_q      <= {tx_q, 40'h0};
            tx_full_q <= 1'b0;
            bits_q    <= frm_q.quad ? 6'd2 : 6'd8;
            unit_q    <= U_TXD;
            state_q   <= ST_SHIFT;
          end else if (frm_q.dmode == DM_RX && (poll_q || !rx_full_q)) begin
            bits_q  <= 6'd8;
            unit_q  <= U_RXD;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !sck_q) begin
            sck_q <= 1'b1;
            in_q  <= {in_q[6:0], din_q[1]};
          end else if (tick) begin
            sck_q <= 1'b0;
            if (bits_q != 6'd1) begin
              sr_q   <= (unit_q == U_TXD && frm_q.quad) ?
                        {sr_q[43:0], 4'h0} : {sr_q[46:0], 1'b0};
              bits_q <= bits_q - 6'd1;
            end else begin
              gap_q <= 8'h00;
              if (unit_q == U_RXD) begin
                if (poll_q) begin
                  stat_q <= in_q;
                end else begin
                  rx_q      <= in_q;
                  rx_full_q <= 1'b1;
                end
              end
              // cs stays low while waiting for data bytes
              if (unit_q == U_HDR) begin
                state_q <= (frm_q.dmode == DM_NONE) ? ST_GAP : ST_STALL;
              end else if (left_q == 16'h1) begin
                state_q <= ST_GAP;
              end else begin
                left_q  <= left_q - 16'h1;
                state_q <= ST_STALL;
              end
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pins registered so clock and data share one delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_o <= '{cs_n: 1'b1, sck: 1'b0, io_o: 4'hc, io_oe: 4'hd};
    end else begin
      pins_o.cs_n <= state_q == ST_IDLE || state_q == ST_GAP;
      pins_o.sck  <= sck_q;
      if (unit_q == U_TXD && frm_q.quad && state_q == ST_SHIFT) begin
        pins_o.io_o  <= sr_q[47:44];
        pins_o.io_oe <= 4'hf;
      end else begin
        // io2 and io3 held high as inactive protect and hold
        pins_o.io_o  <= {2'b11, 1'b0, sr_q[47]};
        pins_o.io_oe <= 4'hd;
      end
    end
  end

endmodule

// ===== verification/nand_host_properties.sv
// concurrent checks on the pins and bus port of the nand host
// assumes binding onto nand_host; one clock domain, async rst
`timescale 1ns/1ps
module nand_host_properties
  import nand_host_pkg::*;
(
  input logic        clk,
  input logic        rst,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic [3:0]  io_i,
  input pins_t       pins_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_idle_sck: assert property (pins_o.cs_n |-> !pins_o.sck)
    else $error("serial clock moves outside frame");
  a_cs_gap: assert property ($rose(pins_o.cs_n) |-> pins_o.cs_n [*8])
    else $error("chip select gap too short");
  a_sck_high: assert property
    ($rose(pins_o.sck) |-> pins_o.sck [*8] ##1 !pins_o.sck)
    else $error("serial clock high phase wrong");
  a_data_hold: assert property
    (pins_o.sck && $past(pins_o.sck) |-> $stable(pins_o.io_o))
    else $error("data moved while clock high");
  a_single_oe: assert property
    (pins_o.io_oe != 4'hf |-> pins_o.io_oe == 4'hd)
    else $error("device output line driven");
  a_quad_frame: assert property (pins_o.io_oe == 4'hf |-> !pins_o.cs_n)
    else $error("quad drive outside frame");

  c_frame_end: cover property ($rose(pins_o.cs_n));
  c_quad_data: cover property (pins_o.io_oe == 4'hf && pins_o.sck);
  c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind nand_host nand_host_properties u_props (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .io_i, .pins_o);

// ===== verification/nand_dev_model.sv
// behavioural serial nand: buffer, sparse array, busy and latch
// assumes mode 0 framing from the host pins; no pull on its output
`timescale 1ns/1ps
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int BUSY_NS = 2000
)
(
  input  pins_t pins,
  input  logic  read_mode_select,
  output logic  dev_o
);
  logic [7:0]  bufm [0:2111];
  logic [7:0]  m [int];
  logic [7:0]  opc, sr, osr;
  logic [23:0] a;
  logic        write_enable_latch, busy, ign;
  int          nb, bi, rp, hb, nprog, nfr;
  wire q = (opc == 8'h32 || opc == 8'h34) && bi >= 3;
  wire ld = (opc inside {8'h02, 8'h84, 8'h32, 8'h34}) && write_enable_latch && !ign;

  initial begin
    write_enable_latch = 0; busy = 0; ign = 0; dev_o = 1; opc = 0;
    nprog = 0; nfr = 0; bi = 0; nb = 0; hb = 99; rp = 0;
  end

  task automatic done(input logic [7:0] o, input int pg);
    #BUSY_NS;
    for (int i = 0; i < 2112; i++)
      if (o == 8'h10) m[pg * 2112 + i] = bufm[i];
      else bufm[i] = m.exists(pg * 2112 + i) ? m[pg * 2112 + i] : 8'hff;
    if (o == 8'h10) begin
      write_enable_latch = 0;
      nprog++;
    end
    busy = 0;
  endtask

  always @(negedge pins.cs_n) begin
    bi = 0; nb = 0; ign = 0; nfr++;
  end

  always @(posedge pins.sck) if (!pins.cs_n) begin
    sr = q ? {sr[3:0], pins.io_o} : {sr[6:0], pins.io_o[0]};
    nb += q ? 4 : 1;
    if (nb == 8) begin
      nb = 0;
      if (bi == 0) begin
        opc = sr;
        ign = busy && sr != 8'h0f;
        hb = sr == 8'h0f ? 2 : read_mode_select ? 4 : 6;
      end else if (ld && bi >= 3) begin
        if (bi == 3 && !opc[2])
          for (int i = 0; i < 2112; i++) bufm[i] = 8'hff;
        bufm[a[11:0] + bi - 3] = sr;
      end else a = {a[15:0], sr};
      if (bi == 2 && opc == 8'h03) rp = read_mode_select ? a[11:0] : 0;
      bi++;
    end
  end

  always @(negedge pins.sck)
    if (!pins.cs_n && !ign && (opc == 8'h03 || opc == 8'h0f) && bi >= hb) begin
      if (nb == 0) begin
        osr = opc == 8'h0f ? {6'h0, write_enable_latch, busy} : rp < 2112 ? bufm[rp] : 8'h0;
        rp++;
      end
      dev_o = opc == 8'h03 && rp > 2112 ? ~dev_o : osr[7 - nb];
    end

  always @(posedge pins.cs_n) begin
    dev_o = ~dev_o; // released line shows no stale bit
    if (opc == 8'h06 && bi == 1) write_enable_latch = 1;
    if (!ign && bi == 4 && (opc == 8'h10 && write_enable_latch || opc == 8'h13)) begin
      busy = 1;
      fork
        done(opc, a[15:0]);
      join_none
    end
  end
endmodule

// ===== verification/serial_nand_program_read_cmds_bench.sv
// self-checking bench: wishbone software side, device model on the pins
// assumes the device model answers status polls during busy
`timescale 1ns/1ps
module serial_nand_program_read_cmds_bench;
  import nand_host_pkg::*;
  logic        clk, rst, cyc, stb, we, rms, dev_o;
  logic [7:0]  adr;
  logic [31:0] dat, dat_o, s;
  logic        ack;
  logic [3:0]  io_i;
  pins_t       pins;
  int          error_cnt, compares, cycles;

  nand_host DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .io_i(io_i), .pins_o(pins));
  nand_dev_model #(.BUSY_NS(2000)) dev (.pins(pins),
    .read_mode_select(rms), .dev_o(dev_o));
  // io1 belongs to the device unless the host drives it in quad data
  assign io_i = {pins.io_o[3:2], pins.io_oe[1] ? pins.io_o[1] : dev_o,
                 pins.io_o[0]};

  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= ad; dat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    r = dat_o;
    cyc <= 0; stb <= 0;
    if (ack !== 1'b1) chk("ack", 32'h1, 32'(ack));
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    wb(1, ad, d, r);
  endtask

  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin wb(0, REG_STATUS, 0, s); n++; end
    while (s[b] !== v && n < 4000);
    chk("status bit", 32'(v), 32'(s[b]));
  endtask

  task automatic load(input logic [3:0] c, input logic [31:0] col,
                      input logic [7:0] d0, input logic [31:0] n);
    wr(REG_ADDR, col); wr(REG_LEN, n); wr(REG_CMD, 32'(c));
    for (int i = 0; i < n; i++) begin
      wait_st(1, 0);
      wr(REG_TXDATA, 32'(d0 + i));
    end
    wait_st(0, 0);
  endtask

  task automatic cmd(input logic [3:0] c, input logic [31:0] ad);
    wr(REG_ADDR, ad); wr(REG_CMD, 32'(c)); wait_st(0, 0);
  endtask

  task automatic rdat(input logic [31:0] ad, input logic [7:0] e [$]);
    wr(REG_ADDR, ad); wr(REG_LEN, e.size()); wr(REG_CMD, 32'(CMD_READ));
    foreach (e[i]) begin
      wait_st(2, 1);
      wb(0, REG_RXDATA, 0, s);
      chk("read byte", 32'(e[i]), s);
    end
    wait_st(0, 0);
  endtask

  task automatic t_regs();
    wb(0, REG_CFG, 0, s); chk("cfg reset", 32'(CFG_RESET), s);
    wb(0, REG_LEN, 0, s); chk("len reset", 32'(LEN_RESET), s);
    wb(0, 8'hfc, 0, s); chk("unmapped", 32'h0, s);
  endtask

  task automatic t_prog();
    load(CMD_LOAD, 32'd2096, 8'h40, 3);
    chk("latch", 1, 32'(dev.write_enable_latch));
    chk("loaded", 32'h40, 32'(dev.bufm[2096]));
    chk("filled", 32'hff, 32'(dev.bufm[0]));
    cmd(CMD_EXEC, 32'h0005_0000);
    chk("programs", 1, dev.nprog);
    chk("latch clear", 0, 32'(dev.write_enable_latch));
    chk("poll busy", 32'h0, 32'(s[8]));
    load(CMD_RLOAD, 32'd2097, 8'h11, 1);
    chk("kept", 32'h40, 32'(dev.bufm[2096]));
    cmd(CMD_PREAD, 32'h0005_0000);
    chk("page back", 32'h41, 32'(dev.bufm[2097]));
    rdat(32'd2095, '{8'hff, 8'h40, 8'h41, 8'h42});
  endtask

  task automatic t_quad();
    int f;
    load(CMD_QLOAD, 32'd0, 8'ha5, 2);
    chk("quad byte", 32'ha6, 32'(dev.bufm[1]));
    chk("quad fill", 32'hff, 32'(dev.bufm[2]));
    wr(REG_CFG, 32'h5);
    f = dev.nfr;
    wr(REG_CMD, 32'(CMD_QRLOAD));
    wb(0, REG_STATUS, 0, s); chk("quad err", 32'h1, 32'(s[3]));
    chk("no frame", f, dev.nfr);
    wr(REG_CFG, 32'h1);
  endtask

  task automatic t_order();
    int p;
    p = dev.nprog;
    wr(REG_ADDR, 32'h0003_0000); wr(REG_CMD, 32'(CMD_EXEC));
    wait_st(0, 0);
    chk("descending", p, dev.nprog);
    for (int k = 1; k <= 4; k++) begin
      cmd(CMD_EXEC, 32'h0005_0000);
      chk("partial", p + (k < 4 ? k : 3), dev.nprog);
    end
  endtask

  task automatic t_cont();
    rms <= 0;
    wr(REG_CFG, 32'h2);
    rdat(32'd7, '{8'ha5, 8'ha6});
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h0; dat = 32'h0;
    rms = 1; error_cnt = 0; compares = 0; cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_prog();
    t_quad();
    t_order();
    t_cont();
    print_verdict();
  end
endmodule
